// ---- scm_core.sv ----
`include "scm_params.svh"
`default_nettype none

// Contract
// RL1: Low-pair enable clear makes inputs 0,1 direct
// RL2: Direct inputs update no status, raise no interrupt
// RL3: Scan code 110 disables adjustable hysteresis
// RL4: One shared debounce timer, 5 to 100 ms
// RL5: Pulses under 20 us are rejected
// RL6: Stable change over debounce updates status, interrupts
// RL7: Reverted input leaves status, raises nothing
// RL8: Scan-mode change wakes into normal mode
// RL9: After debounce or revert, back to scan
// RL10: Wetting off at power-up; enables and mode
// RL11: Confirmed change starts pulse on closed switches
// RL12: One wetting timer, restarted by new closures
// RL13: Scan mode wets only during polls
// RL14: Direct outputs off when enabled or scanning
// RL15: Interrupt pin asserts on permitted changes, any time
// RL16: Chip select fall clears interrupt and overtemp pins
// RL17: Overtemperature disables wetting while warning persists
// RL18: Overtemp status bit follows warning with hysteresis
// RL19: 16-bit status read, command write, MSB first
// RL20: Chip select fall loads status; out on rising
// RL21: Input sampled on falling; rise copies command
// RL22: Master gives exactly 16 clocks per frame
// RL23: Chip select high: output off, clock ignored
// RL24: Command word is zero after power-on
// RL25: Status reads 1 for closed switch
// RL26: Codes 0-5 poll 64..2 ms; 6,7 continuous
// RL27: Timers count ticks of an internal time base
module scm_core
   import scm_pkg::*;
#(
   parameter int TICK_CYCLES = `SCM_TICK_NS / `SCM_CLK_NS,
   parameter int POLL_CYCLES = `SCM_POLL_NS / `SCM_CLK_NS
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic SHUTDOWN_N,
   input wire logic [7:0] SWITCH_LEVEL,
   input wire logic OVERTEMP_IN,
   input wire logic [6:0] DEBOUNCE_TIME_MS,
   input wire logic SPI_CLK,
   input wire logic CS_N,
   input wire logic SDI,
   output logic SDO,
   output logic SDO_OE,
   output logic INT_N_OUT,
   output logic INT_N_OE,
   output logic OT_N_OUT,
   output logic OT_N_OE,
   output logic [1:0] DIRECT_OUT,
   output logic [1:0] DIRECT_OE,
   output logic [7:0] SENSE_EN,
   output logic [7:0] PULL_DOWN_SEL,
   output logic [7:0] WET_EN,
   output logic ADJ_HYST_EN
);

   // ==================================================
   // Functions
   function automatic logic [6:0] period_ms(input logic [2:0] code);
      period_ms = 7'(`SCM_PERIOD_MAX_MS >> code);
   endfunction

   function automatic logic [6:0] clamp_deb(input logic [6:0] ms);
      if (ms < 7'(`SCM_DEB_MIN_MS)) begin
         clamp_deb = 7'(`SCM_DEB_MIN_MS);
      end else if (ms > 7'(`SCM_DEB_MAX_MS)) begin
         clamp_deb = 7'(`SCM_DEB_MAX_MS);
      end else begin
         clamp_deb = ms;
      end
   endfunction

   // ==================================================
   // Declarations
   scm_cmd_t cmd_reg;
   scm_status_t status_hold_reg;
   scm_sense_state_t state_reg;
   logic [15:0] rx_shift_reg;
   logic [4:0] tx_idx_reg;
   logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
   logic [7:0] lvl_meta_reg, lvl_sync_reg;
   logic ot_meta_reg, ot_sync_reg, ot_prev_reg;
   logic sd_meta_reg, sd_sync_reg;
   logic [7:0] filt_reg, status_reg, pend_prev_reg, wet_mask_reg;
   logic [11:0] glitch_cnt_reg [8];
   logic [16:0] tick_cnt_reg;
   logic tick;
   logic [6:0] deb_cnt_reg, period_cnt_reg, wet_cnt_reg;
   logic [14:0] poll_cnt_reg;
   logic wet_run_reg, int_flag_reg, ot_flag_reg;
   logic cs_fall, cs_rise, direct_mode, scan_code, sense_on, confirm;
   logic [7:0] closed_now, track_mask, pending, ch_wet_en, wet_base;

   // ==================================================
   // Link domain
   // Sampling on the falling clock edge, gated by chip select
   always_ff @(negedge SPI_CLK) begin
      if (!CS_N) begin // see RL23
         rx_shift_reg <= {rx_shift_reg[14:0], SDI}; // see RL21
      end
   end

   // Chip select high holds the index at zero; only a constant is loaded
   always_ff @(posedge SPI_CLK or posedge CS_N) begin
      if (CS_N) begin
         tx_idx_reg <= 5'h00; // see RL23
      end else if (tx_idx_reg != 5'(`SCM_WORD_BITS)) begin
         tx_idx_reg <= tx_idx_reg + 5'h01; // see RL20
      end
   end

   // First rising edge keeps the MSB, each later one steps one bit down
   always_comb begin
      if (tx_idx_reg == 5'h00) begin
         SDO = status_hold_reg[15]; // see RL19
      end else begin
         SDO = status_hold_reg[4'(5'(`SCM_WORD_BITS) - tx_idx_reg)]; // see RL20
      end
   end
   assign SDO_OE = ~CS_N; // see RL23

   // ==================================================
   // Synchronisers
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
         lvl_meta_reg <= 8'h00;
         lvl_sync_reg <= 8'h00;
         ot_meta_reg <= 1'b0;
         ot_sync_reg <= 1'b0;
         ot_prev_reg <= 1'b0;
         sd_meta_reg <= 1'b0;
         sd_sync_reg <= 1'b0;
      end else begin
         cs_meta_reg <= CS_N;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
         lvl_meta_reg <= SWITCH_LEVEL;
         lvl_sync_reg <= lvl_meta_reg;
         ot_meta_reg <= OVERTEMP_IN;
         ot_sync_reg <= ot_meta_reg;
         ot_prev_reg <= ot_sync_reg;
         sd_meta_reg <= SHUTDOWN_N;
         sd_sync_reg <= sd_meta_reg;
      end
   end
   assign cs_fall = cs_prev_reg & ~cs_sync_reg;
   assign cs_rise = ~cs_prev_reg & cs_sync_reg;

   // ==================================================
   // Command and status words
   // Shift register is quiet while chip select is high, so the copy is safe
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         cmd_reg <= scm_cmd_t'(`SCM_CMD_POR); // see RL24
      end else if (cs_rise) begin
         cmd_reg <= scm_cmd_t'(rx_shift_reg); // see RL21
      end
   end

   // Snapshot frozen while the frame runs, read by the link side
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         status_hold_reg <= scm_status_t'(16'h0000);
      end else if (cs_sync_reg) begin
         status_hold_reg <= {status_reg, ot_sync_reg, 7'h00}; // see RL20, RL18, RL25
      end
   end

   // ==================================================
   // Configuration decode
   assign direct_mode = ~cmd_reg.low_pair_wetting_enable; // see RL1
   assign scan_code = cmd_reg.scan_period_select < `SCM_SC_FIRST_CONT;
   assign track_mask = direct_mode ? `SCM_DIRECT_MASK : `SCM_ALL_MASK; // see RL2
   assign PULL_DOWN_SEL = {{2{cmd_reg.pair_polarity_sel_hi}},
                           {2{cmd_reg.pair_polarity_sel_lo}}, 4'h0};
   assign closed_now = ~(lvl_sync_reg ^ PULL_DOWN_SEL); // see RL25
   assign sense_on = sd_sync_reg & (state_reg != SCM_IDLE);
   assign pending = (filt_reg ^ status_reg) & track_mask;

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ADJ_HYST_EN <= 1'b1;
      end else begin
         ADJ_HYST_EN <= cmd_reg.scan_period_select != `SCM_SC_HYST_OFF; // see RL3
      end
   end

   // ==================================================
   // Deglitch
   // A level must hold for the whole window of sensed time to pass
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         filt_reg <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            glitch_cnt_reg[i] <= 12'h000;
         end
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (!sense_on || closed_now[i] == filt_reg[i]) begin
               glitch_cnt_reg[i] <= 12'h000; // see RL5
            end else if (glitch_cnt_reg[i] == 12'(`SCM_GLITCH_CYCLES - 1)) begin
               glitch_cnt_reg[i] <= 12'h000;
               filt_reg[i] <= closed_now[i]; // see RL5
            end else begin
               glitch_cnt_reg[i] <= glitch_cnt_reg[i] + 12'h001;
            end
         end
      end
   end

   // ==================================================
   // Millisecond time base
   always_ff @(posedge CLK) begin
      if (!RESET_N || tick) begin
         tick_cnt_reg <= 17'h00000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 17'h00001; // see RL27
      end
   end
   assign tick = tick_cnt_reg == 17'(TICK_CYCLES - 1);

   // ==================================================
   // Shared debounce
   // Resolution is one tick, so the real wait is up to 1 ms longer
   assign confirm = (pending != 8'h00) && (pending == pend_prev_reg)
                    && (deb_cnt_reg > clamp_deb(DEBOUNCE_TIME_MS)); // see RL4, RL6

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         deb_cnt_reg <= 7'h00;
         pend_prev_reg <= 8'h00;
      end else begin
         pend_prev_reg <= pending;
         if (pending != pend_prev_reg || pending == 8'h00 || confirm) begin
            deb_cnt_reg <= 7'h00; // see RL4, RL7
         end else if (tick) begin
            deb_cnt_reg <= deb_cnt_reg + 7'h01; // see RL27
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         status_reg <= 8'h00;
      end else if (confirm) begin
         status_reg <= (filt_reg & track_mask) | (status_reg & ~track_mask); // see RL6, RL2
      end
   end

   // ==================================================
   // Sensing schedule
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         state_reg <= SCM_CONT;
         period_cnt_reg <= 7'h00;
         poll_cnt_reg <= 15'h0000;
      end else begin
         case (state_reg)
            SCM_CONT: begin
               period_cnt_reg <= 7'h00;
               if (scan_code && pending == 8'h00) begin
                  state_reg <= SCM_IDLE;
               end
            end
            SCM_IDLE: begin
               if (!scan_code) begin
                  state_reg <= SCM_CONT; // see RL26
               end else if (tick) begin
                  if (period_cnt_reg + 7'h01 >= period_ms(cmd_reg.scan_period_select)) begin
                     period_cnt_reg <= 7'h00;
                     poll_cnt_reg <= 15'h0000;
                     state_reg <= SCM_POLL; // see RL26
                  end else begin
                     period_cnt_reg <= period_cnt_reg + 7'h01;
                  end
               end
            end
            SCM_POLL: begin
               poll_cnt_reg <= poll_cnt_reg + 15'h0001;
               if (!scan_code) begin
                  state_reg <= SCM_CONT;
               end else if (poll_cnt_reg == 15'(POLL_CYCLES - 1)) begin
                  state_reg <= (pending != 8'h00) ? SCM_WAKE : SCM_IDLE; // see RL8
               end
            end
            SCM_WAKE: begin
               // Stays awake until confirmed or reverted
               if (!scan_code) begin
                  state_reg <= SCM_CONT;
               end else if (pending == 8'h00) begin
                  state_reg <= SCM_IDLE; // see RL9
               end
            end
            default: begin
               state_reg <= SCM_CONT;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         SENSE_EN <= 8'h00;
      end else begin
         SENSE_EN <= {8{sense_on}} & ~(direct_mode ? 8'h03 : 8'h00); // see RL1
      end
   end

   // ==================================================
   // Direct outputs
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         DIRECT_OUT <= 2'h0;
         DIRECT_OE <= 2'h0;
      end else begin
         DIRECT_OUT <= lvl_sync_reg[1:0]; // see RL1
         DIRECT_OE <= {2{direct_mode && state_reg != SCM_IDLE
                         && state_reg != SCM_POLL}}; // see RL14
      end
   end

   // ==================================================
   // Wetting
   // Pulse mask is taken at confirmation; each later confirmation reloads it from filt_reg
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         wet_run_reg <= 1'b0;
         wet_cnt_reg <= 7'h00;
         wet_mask_reg <= 8'h00;
      end else if (confirm) begin
         wet_run_reg <= 1'b1; // see RL11, RL12
         wet_cnt_reg <= 7'h00; // see RL12
         wet_mask_reg <= filt_reg; // see RL11
      end else if (wet_run_reg && tick) begin
         if (wet_cnt_reg == 7'(`SCM_WET_MS - 1)) begin
            wet_run_reg <= 1'b0;
         end
         wet_cnt_reg <= wet_cnt_reg + 7'h01; // see RL27
      end
   end

   assign ch_wet_en = {{6{cmd_reg.global_wetting_enable}},
                       {2{cmd_reg.global_wetting_enable & cmd_reg.low_pair_wetting_enable}}};
   assign wet_base = cmd_reg.wetting_continuous_mode ? status_reg
                     : (wet_run_reg ? wet_mask_reg : 8'h00); // see RL10

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         WET_EN <= 8'h00; // see RL10
      end else if (!sense_on || (ot_sync_reg && (status_reg != 8'h00))) begin
         WET_EN <= 8'h00; // see RL13, RL17
      end else begin
         WET_EN <= wet_base & ch_wet_en & track_mask & status_reg; // see RL10
      end
   end

   // ==================================================
   // Alert pins
   // A set in the clearing cycle wins so no event is lost
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         int_flag_reg <= 1'b0;
      end else if (confirm && ((filt_reg ^ status_reg) & track_mask
                               & ~cmd_reg.irq_prohibit_bits) != 8'h00) begin
         int_flag_reg <= 1'b1; // see RL15, RL6
      end else if (cs_fall) begin
         int_flag_reg <= 1'b0; // see RL16
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ot_flag_reg <= 1'b0;
      end else if (ot_sync_reg && !ot_prev_reg) begin
         ot_flag_reg <= 1'b1;
      end else if (cs_fall) begin
         ot_flag_reg <= 1'b0; // see RL16
      end
   end

   assign INT_N_OUT = 1'b0;
   assign INT_N_OE = int_flag_reg;
   assign OT_N_OUT = 1'b0;
   assign OT_N_OE = ot_flag_reg;

endmodule
`default_nettype wire

// ---- scm_core_bench.sv ----
`default_nettype none
module scm_core_bench;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========
   // Short tick so millisecond timers stay cheap
   localparam int TICK = 100;
   logic CLK, RESET_N, SHUTDOWN_N, OVERTEMP_IN, SPI_CLK, CS_N, SDI, SDO, SDO_OE;
   logic INT_N_OE, OT_N_OE, ADJ_HYST_EN;
   logic [7:0] SWITCH_LEVEL, SENSE_EN, WET_EN, PULL_DOWN_SEL;
   logic [6:0] DEBOUNCE_TIME_MS;
   logic [1:0] DIRECT_OUT, DIRECT_OE;
   logic [15:0] rx;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;

   scm_core #(.TICK_CYCLES(TICK), .POLL_CYCLES(2100)) u_dut (
      .CLK(CLK), .RESET_N(RESET_N), .SHUTDOWN_N(SHUTDOWN_N), .SWITCH_LEVEL(SWITCH_LEVEL),
      .OVERTEMP_IN(OVERTEMP_IN), .DEBOUNCE_TIME_MS(DEBOUNCE_TIME_MS), .SPI_CLK(SPI_CLK),
      .CS_N(CS_N), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE), .INT_N_OUT(), .INT_N_OE(INT_N_OE),
      .OT_N_OUT(), .OT_N_OE(OT_N_OE), .DIRECT_OUT(DIRECT_OUT), .DIRECT_OE(DIRECT_OE),
      .SENSE_EN(SENSE_EN), .PULL_DOWN_SEL(PULL_DOWN_SEL), .WET_EN(WET_EN),
      .ADJ_HYST_EN(ADJ_HYST_EN)
   );

   scm_spi_master u_spi (
      .SPI_CLK(SPI_CLK), .CS_N(CS_N), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE)
   );

   initial begin
      CLK = 1'h0;
      forever #5 CLK = ~CLK;
   end

   // ==========
   // Hang guard
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         final_report();
      end
   end

   // ==========
   // Shared helpers
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
   endtask

   task automatic frame(input logic [15:0] cmd, input logic [15:0] exp);
      u_spi.xfer(cmd, 62.5, rx);
      check("status word", rx, exp);
      cyc(4);
   endtask

   task automatic wait_int(input int lim);
      int n = 0;
      while (INT_N_OE !== 1'h1 && n < lim) begin
         @(posedge CLK);
         n++;
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========
   // Scenarios
   task automatic t_por();
      check("wet at reset", WET_EN, 16'h0);
      check("hyst at reset", ADJ_HYST_EN, 16'h1);
      check("direct in scan", DIRECT_OE, 16'h0);
      frame(16'h7800, 16'h0000);
      cyc(10);
      check("direct on", DIRECT_OE, 16'h3);
      check("pair sense", SENSE_EN[1:0], 16'h0);
   endtask

   task automatic t_direct();
      SWITCH_LEVEL[0] <= 1'h0;
      cyc(8);
      check("direct level", DIRECT_OUT, 16'h2);
      cyc(2700);
      check("direct irq", INT_N_OE, 16'h0);
      frame(16'h7800, 16'h0000);
      SWITCH_LEVEL[0] <= 1'h1;
      // Filter must settle before the pair rejoins tracking
      cyc(2100);
   endtask

   task automatic t_debounce();
      frame(16'h7c00, 16'h0000);
      SWITCH_LEVEL[3] <= 1'h0;
      cyc(2400);
      check("early irq", INT_N_OE, 16'h0);
      wait_int(700);
      check("irq", INT_N_OE, 16'h1);
      cyc(2);
      check("wet pulse", WET_EN, 16'h8);
      cyc(2200);
      check("wet end", WET_EN, 16'h0);
      frame(16'h6c00, 16'h0800);
      check("irq cleared", INT_N_OE, 16'h0);
      check("hyst off", ADJ_HYST_EN, 16'h0);
   endtask

   task automatic t_reject();
      SWITCH_LEVEL[4] <= 1'h0;
      cyc(1000);
      SWITCH_LEVEL[4] <= 1'h1;
      cyc(3000);
      check("glitch", INT_N_OE, 16'h0);
      DEBOUNCE_TIME_MS <= 7'h64;
      SWITCH_LEVEL[5] <= 1'h0;
      cyc(5000);
      SWITCH_LEVEL[5] <= 1'h1;
      cyc(9000);
      check("reverted", INT_N_OE, 16'h0);
      frame(16'h6c00, 16'h0800);
      DEBOUNCE_TIME_MS <= 7'h05;
   endtask

   task automatic t_wet_ot();
      frame(16'hfc40, 16'h0800);
      SWITCH_LEVEL[6] <= 1'h0;
      cyc(3400);
      check("prohibited", INT_N_OE, 16'h0);
      check("wet steady", WET_EN, 16'h48);
      OVERTEMP_IN <= 1'h1;
      cyc(8);
      check("ot wet", WET_EN, 16'h0);
      check("ot pin", OT_N_OE, 16'h1);
      frame(16'hfc40, 16'h4880);
      check("ot pin cleared", OT_N_OE, 16'h0);
      frame(16'hfc40, 16'h4880);
      OVERTEMP_IN <= 1'h0;
      cyc(8);
      check("wet back", WET_EN, 16'h48);
   endtask

   task automatic t_scan();
      frame(16'h0800, 16'h4800);
      cyc(10);
      check("scan direct", DIRECT_OE, 16'h0);
      SWITCH_LEVEL[2] <= 1'h0;
      wait_int(12000);
      check("scan irq", INT_N_OE, 16'h1);
      frame(16'h0800, 16'h4c00);
      frame(16'h0b00, 16'h4c00);
      check("pull-down select", PULL_DOWN_SEL, 16'hf0);
   endtask

   initial begin
      RESET_N = 1'h0;
      SHUTDOWN_N = 1'h1;
      OVERTEMP_IN = 1'h0;
      SWITCH_LEVEL = 8'hff;
      DEBOUNCE_TIME_MS = 7'h05;
      cyc(6);
      RESET_N <= 1'h1;
      cyc(4);
      t_por();
      t_direct();
      t_debounce();
      t_reject();
      t_wet_ot();
      t_scan();
      final_report();
   end
endmodule
`default_nettype wire

// ---- scm_core_sva.sv ----
`default_nettype none
module scm_core_sva (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [7:0] SWITCH_LEVEL,
   input wire logic OVERTEMP_IN,
   input wire logic SPI_CLK,
   input wire logic CS_N,
   input wire logic SDO,
   input wire logic SDO_OE,
   input wire logic INT_N_OUT,
   input wire logic INT_N_OE,
   input wire logic OT_N_OUT,
   input wire logic OT_N_OE,
   input wire logic [1:0] DIRECT_OUT,
   input wire logic [1:0] DIRECT_OE,
   input wire logic [7:0] SENSE_EN,
   input wire logic [7:0] WET_EN
);
   // ==========
   // Core-clock checks; link signals are sampled as data
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   chk_sdo_enable: assert property (SDO_OE == !CS_N)
      else $error("serial out enable does not follow select");
   chk_flag_clear: assert property ($fell(CS_N) |-> ##[1:4] (!INT_N_OE && !OT_N_OE))
      else $error("flags not cleared after select fall");
   chk_pins_low: assert property (!INT_N_OUT && !OT_N_OUT)
      else $error("open-drain pin drives high");
   chk_int_holds: assert property (INT_N_OE && CS_N |=> INT_N_OE)
      else $error("interrupt dropped without select");
   chk_direct_quiet: assert property (DIRECT_OE[0] [*3] |->
      (SENSE_EN[1:0] == 2'h0 && WET_EN[1:0] == 2'h0))
      else $error("direct pair still sensed or wetted");
   chk_direct_pair: assert property (DIRECT_OE[0] == DIRECT_OE[1])
      else $error("direct enables differ");
   chk_direct_follow: assert property ((DIRECT_OE[0] && $stable(SWITCH_LEVEL[0])) [*4] |->
      DIRECT_OUT[0] == SWITCH_LEVEL[0])
      else $error("direct output not following input");
   chk_wet_overtemp: assert property (OVERTEMP_IN [*4] |-> WET_EN == 8'h00)
      else $error("wetting on during overtemperature");
   chk_ot_pin_set: assert property ($rose(OVERTEMP_IN) ##1 CS_N [*5] |-> OT_N_OE)
      else $error("overtemperature pin not asserted");
   chk_sdo_steady: assert property (!CS_N [*5] ##0 $stable(SPI_CLK) |-> $stable(SDO))
      else $error("serial out moved without clock rise");

   cov_int: cover property ($rose(INT_N_OE));
   cov_ot: cover property ($rose(OT_N_OE));
   cov_direct: cover property ($rose(DIRECT_OE[0]));
   cov_wet: cover property (WET_EN != 8'h00);
endmodule

bind scm_core scm_core_sva u_sva (
   .CLK(CLK), .RESET_N(RESET_N), .SWITCH_LEVEL(SWITCH_LEVEL), .OVERTEMP_IN(OVERTEMP_IN),
   .SPI_CLK(SPI_CLK), .CS_N(CS_N), .SDO(SDO), .SDO_OE(SDO_OE), .INT_N_OUT(INT_N_OUT),
   .INT_N_OE(INT_N_OE), .OT_N_OUT(OT_N_OUT), .OT_N_OE(OT_N_OE), .DIRECT_OUT(DIRECT_OUT),
   .DIRECT_OE(DIRECT_OE), .SENSE_EN(SENSE_EN), .WET_EN(WET_EN)
);
`default_nettype wire

// ---- scm_params.svh ----
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH

// ==================================================
// Timing
`define SCM_CLK_NS 10
`define SCM_GLITCH_NS 20000
`define SCM_GLITCH_CYCLES ((`SCM_GLITCH_NS + `SCM_CLK_NS - 1) / `SCM_CLK_NS)
`define SCM_TICK_NS 1000000
`define SCM_POLL_NS 250000
`define SCM_WET_MS 20
`define SCM_DEB_MIN_MS 5
`define SCM_DEB_MAX_MS 100
`define SCM_PERIOD_MAX_MS 64

// ==================================================
// Words and codes
`define SCM_CMD_POR 16'h0000
`define SCM_WORD_BITS 16
`define SCM_SC_HYST_OFF 3'h6
`define SCM_SC_FIRST_CONT 3'h6
`define SCM_DIRECT_MASK 8'hfc
`define SCM_ALL_MASK 8'hff

`endif

// ---- scm_pkg.sv ----
`default_nettype none
package scm_pkg;
   // ==================================================
   // Command word, most significant field first
   typedef struct packed {
      logic wetting_continuous_mode;
      logic [2:0] scan_period_select;
      logic global_wetting_enable;
      logic low_pair_wetting_enable;
      logic pair_polarity_sel_hi;
      logic pair_polarity_sel_lo;
      logic [7:0] irq_prohibit_bits;
   } scm_cmd_t;

   // Status word
   typedef struct packed {
      logic [7:0] switch_closed;
      logic overtemp_warning;
      logic [6:0] unused;
   } scm_status_t;

   // Sensing schedule
   typedef enum logic [1:0] {
      SCM_CONT = 2'b00,
      SCM_IDLE = 2'b01,
      SCM_POLL = 2'b10,
      SCM_WAKE = 2'b11
   } scm_sense_state_t;
endpackage
`default_nettype wire

// ---- scm_spi_master.sv ----
`default_nettype none
module scm_spi_master (
   output logic SPI_CLK,
   output logic CS_N,
   output logic SDI,
   input wire logic SDO,
   input wire logic SDO_OE
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========
   // Idle: clock parked low, input line at its pull-down level
   initial begin
      SPI_CLK = 1'h0;
      CS_N = 1'h1;
      SDI = 1'h0;
   end

   // ==========
   // One frame; hp sets the speed, clock runs only inside it
   task automatic xfer(input logic [15:0] tx, input realtime hp, output logic [15:0] rx);
      // Off the core clock edge; the two clocks are unrelated
      #2;
      CS_N = 1'h0;
      #(hp);
      for (int i = 15; i >= 0; i--) begin
         SPI_CLK = 1'h1;
         SDI = tx[i];
         #(hp);
         rx[i] = SDO_OE ? SDO : 1'bx;
         SPI_CLK = 1'h0;
         #(hp);
      end
      CS_N = 1'h1;
      SDI = 1'h0;
      #(hp);
   endtask
endmodule
`default_nettype wire
